// ---- sim/wk_tx_model.sv ----
// transmitter model sending manchester chips to the wake-up unit
`default_nettype none
module wk_tx_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [63:0] chips,
  input wire logic [6:0] len,
  output logic busy,
  output logic chip_valid,
  output logic chip_data,
  output logic ref_edge,
  output logic sixteenth_tick
);
  logic [63:0] sr;
  logic [6:0] left;
  logic [2:0] ph;
  logic last;
  // one chip every eight cycles, so a tick each cycle is a sixteenth of a bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {busy, chip_valid, chip_data, ref_edge, sixteenth_tick, last} <= '0;
      sr <= '0;
      left <= '0;
      ph <= '0;
    end else begin
      sixteenth_tick <= 1'h1;
      chip_valid <= 1'h0;
      ref_edge <= 1'h0;
      // between chips the line shows the inverse of its last value
      chip_data <= ~chip_data;
      ph <= ph + 3'h1;
      if (go && !busy) begin
        sr <= chips;
        left <= len;
        busy <= len != 7'h00;
        ph <= '0;
      end else if (busy && ph == 3'h7) begin
        chip_valid <= 1'h1;
        chip_data <= sr[63];
        ref_edge <= sr[63] != last;
        last <= sr[63];
        sr <= {sr[62:0], 1'h0};
        left <= left - 7'h01;
        busy <= left != 7'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/wk_wake_unit_asserts.sv ----
// port checks of the wake-up unit
`default_nettype none
module wk_wake_unit_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic frame_gap,
  input wire logic end_of_message,
  input wire logic poll_start,
  input wire logic wake_found,
  input wire logic search_abort,
  input wire logic search_active,
  input wire logic symbol_sync
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_result;
    wake_found || search_abort;
  endsequence
  property p_zero_wait; s_setup |=> pready; endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("no ready after setup");
  property p_ready_access; pready |-> psel && penable; endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("ready outside access");
  property p_wake_pulse; wake_found |=> !wake_found && !search_active; endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake pulse too long or search goes on");
  property p_one_result; s_result |-> !(wake_found && search_abort) && $past(search_active);
  endproperty
  a_one_result: assert property (p_one_result)
    else $error("result outside a search");
  property p_start; $rose(search_active) |-> $past(poll_start); endproperty
  a_start: assert property (p_start)
    else $error("search began without a poll");
  property p_eom; end_of_message && !frame_gap |=> !symbol_sync; endproperty
  a_eom: assert property (p_eom)
    else $error("lock kept after end of message");
  property p_gap; frame_gap && symbol_sync && !end_of_message |=> symbol_sync; endproperty
  a_gap: assert property (p_gap)
    else $error("lock lost in gap");
  property p_loss; search_active && $fell(symbol_sync) |-> ##[0:3] s_result; endproperty
  a_loss: assert property (p_loss)
    else $error("search kept after sync loss");
endmodule
bind wk_wake_unit wk_wake_unit_asserts wk_wake_unit_asserts_i (.pclk, .presetn, .psel,
  .penable, .pready, .frame_gap, .end_of_message, .poll_start, .wake_found, .search_abort,
  .search_active, .symbol_sync);
`default_nettype wire

// ---- sim/wk_wake_unit_tb.sv ----
// self-checking bench of the wake-up unit
`default_nettype none
module wk_wake_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] ONES = 64'hAAAA_AAAA_AAAA_AAAA;
  localparam logic [63:0] MIX = 64'h9999_9999_9999_9999;
  localparam logic [63:0] PATS = 64'hAAAA_9669_AAAA_AAAA;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, go, busy;
  logic chip_valid, chip_data, ref_edge, sixteenth_tick, frame_gap, end_of_message;
  logic poll_start, wake_found, search_abort, search_active, symbol_sync;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [7:0] prop, integ;
  logic [63:0] chips;
  logic [6:0] len;
  int error_cnt, comparisons, cyc, pre, nc;
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  wk_wake_unit wk_wake_unit_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .chip_valid, .chip_data, .ref_edge, .sixteenth_tick,
    .frame_gap, .end_of_message, .poll_start, .wake_found, .search_abort, .search_active,
    .symbol_sync, .recovery_proportional_params(prop), .recovery_integral_params(integ));
  wk_tx_model wk_tx_model_i (.pclk, .presetn, .go, .chips, .len, .busy, .chip_valid,
    .chip_data, .ref_edge, .sixteenth_tick);
  // chips seen in a search, before and after the lock
  always @(posedge pclk) begin
    cyc++;
    if (chip_valid === 1'h1 && search_active === 1'h1) begin
      if (symbol_sync === 1'h1) nc++;
      else pre++;
    end
    if (cyc == 40000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd0(input logic [7:0] idx, input logic err);
    apb(1'h0, idx, 32'h0000_0000);
    check(rdata, 32'h0000_0000);
    check(rerr, err);
  endtask
  task automatic cfg(input logic [1:0] crit, input logic [15:0] pat, input logic [6:0] cnt);
    apb(1'h1, wk_pkg::IDX_CRIT_A, 32'(crit));
    apb(1'h1, wk_pkg::IDX_PAT_LOW_A, 32'(pat[7:0]));
    apb(1'h1, wk_pkg::IDX_PAT_HIGH_A, 32'(pat[15:8]));
    apb(1'h1, wk_pkg::IDX_CHIP_COUNT_A, 32'(cnt));
  endtask
  task automatic start(input logic [63:0] c, input logic [6:0] n);
    pre = 0;
    nc = 0;
    @(posedge pclk);
    poll_start <= 1'h1;
    chips <= c;
    len <= n;
    go <= 1'h1;
    @(posedge pclk);
    poll_start <= 1'h0;
    go <= 1'h0;
  endtask
  task automatic finish(input logic w, input int want_nc);
    int k;
    k = 0;
    while (wake_found !== 1'h1 && search_abort !== 1'h1 && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    check(wake_found, w);
    check(search_abort, !w);
    if (want_nc >= 0) check(nc, want_nc);
    while (busy === 1'h1) @(posedge pclk);
    end_of_message <= 1'h1;
    @(posedge pclk);
    end_of_message <= 1'h0;
    @(posedge pclk);
    check(symbol_sync, 1'h0);
  endtask
  task automatic t_regs;
    check(prop, 32'(wk_pkg::CFG_RESET));
    check(integ, 32'(wk_pkg::CFG_RESET));
    apb(1'h1, wk_pkg::IDX_PROP_A, 32'h0000_00E6);
    apb(1'h1, wk_pkg::IDX_INTEG_A, 32'h0000_0065);
    apb(1'h1, wk_pkg::IDX_PROP_B, 32'h0000_005A);
    apb(1'h1, wk_pkg::IDX_INTEG_B, 32'h0000_003C);
    apb(1'h1, wk_pkg::IDX_SYNC_PREAMBLE_A, 32'h0000_0001);
    apb(1'h1, wk_pkg::IDX_VWIN_A, 32'h0000_0028);
    rd0(wk_pkg::IDX_CRIT_A, 1'h0);
    rd0(wk_pkg::IDX_PROP_A, 1'h0);
    rd0(8'h30, 1'h1);
    check(prop, 32'h0000_00E6);
    check(integ, 32'h0000_0065);
    apb(1'h1, wk_pkg::IDX_CONTROL, 32'h0000_0002);
    start(ONES, 7'h00);
    repeat (2) @(posedge pclk);
    check(search_active, 1'h0);
    apb(1'h0, wk_pkg::IDX_CONTROL, 32'h0000_0000);
    check(rdata, 32'h0000_0002);
    check(prop, 32'h0000_005A);
    check(integ, 32'h0000_003C);
    apb(1'h1, wk_pkg::IDX_CONTROL, 32'h0000_0001);
    $display("register test done");
  endtask
  task automatic t_random;
    cfg(2'h1, 16'h0000, 7'h08);
    start(ONES, 7'h18);
    finish(1'h1, 8);
    check(pre, 7);
    start(64'hAAA0_AAAA_AAAA_AAAA, 7'h28);
    finish(1'h0, 7);
    cfg(2'h1, 16'h0000, 7'h0C);
    start(MIX, 7'h1E);
    finish(1'h1, 12);
    start(64'h0000_0000_0000_0000, 7'h28);
    finish(1'h0, -1);
    check(pre, 8);
    cfg(2'h1, 16'h0000, 7'h00);
    start(ONES, 7'h14);
    finish(1'h1, 0);
    $display("random bits test done");
  endtask
  task automatic t_equal;
    cfg(2'h2, 16'h0000, 7'h0A);
    start(ONES, 7'h1E);
    finish(1'h1, 10);
    start(MIX, 7'h1E);
    finish(1'h0, -1);
    $display("equal bits test done");
  endtask
  task automatic t_pattern;
    cfg(2'h0, 16'h9669, 7'h30);
    start(PATS, 7'h3C);
    finish(1'h1, 25);
    cfg(2'h0, 16'h0000, 7'h11);
    start(PATS, 7'h3C);
    finish(1'h0, 17);
    cfg(2'h0, 16'h9669, 7'h00);
    start(ONES, 7'h14);
    finish(1'h0, 0);
    $display("pattern test done");
  endtask
  task automatic t_rate;
    cfg(2'h3, 16'h0000, 7'h05);
    start(ONES, 7'h14);
    finish(1'h1, 0);
    start(64'h0000_0000_0000_0000, 7'h30);
    finish(1'h0, -1);
    $display("data rate test done");
  endtask
  task automatic t_loss;
    cfg(2'h1, 16'h0000, 7'h64);
    start(ONES, 7'h20);
    @(posedge pclk);
    while (busy === 1'h1) @(posedge pclk);
    frame_gap <= 1'h1;
    repeat (100) @(posedge pclk);
    check(symbol_sync, 1'h1);
    frame_gap <= 1'h0;
    repeat (20) @(posedge pclk);
    check(symbol_sync, 1'h1);
    finish(1'h0, 25);
    $display("sync loss test done");
  endtask
  task automatic wrap_up;
    $display("%0d compared, %0d wrong", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, frame_gap, end_of_message, poll_start, go} = '0;
    paddr = '0;
    pwdata = '0;
    chips = '0;
    len = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_random();
    t_equal();
    t_pattern();
    t_rate();
    t_loss();
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- src/wk_chip_detect.sv ----
// code violation, bit change and 16-chip pattern detectors
`default_nettype none
module wk_chip_detect (
  input wire logic pclk,
  input wire logic presetn,
  wk_chip_if.det chip
);
  typedef struct packed {
    logic [15:0] hist;
    logic [4:0] fill;
    logic done;
    logic viol;
    logic change;
    logic hit;
  } wk_det_state_t;

  wk_det_state_t s;
  wk_det_state_t next_s;
  logic [15:0] shifted;

  assign shifted = {s.hist[14:0], chip.chip_data};

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.viol = 1'b0;
    next_s.change = 1'b0;
    next_s.hit = 1'b0;
    if (chip.restart) begin
      next_s.fill = '0;
    end else if (chip.chip_valid) begin
      next_s.hist = shifted;
      next_s.done = 1'b1;
      // three equal chips in a row
      next_s.viol = (s.fill >= wk_pkg::VIOL_DEPTH) && (chip.chip_data == s.hist[0])
        && (chip.chip_data == s.hist[1]);
      // two equal chips mark a change of bit value
      next_s.change = (s.fill >= wk_pkg::CHANGE_DEPTH)
        && (chip.chip_data == s.hist[0]);
      // compare only once the shifter holds a full pattern
      next_s.hit = (s.fill >= wk_pkg::PATTERN_CHIPS - 5'h01)
        && (shifted == chip.pattern);
      if (s.fill != wk_pkg::PATTERN_CHIPS) begin
        next_s.fill = s.fill + 5'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign chip.done = s.done;
  assign chip.viol = s.viol;
  assign chip.change = s.change;
  assign chip.hit = s.hit;
endmodule
`default_nettype wire

// ---- src/wk_chip_if.sv ----
// chip stream and per-chip detector flags shared inside the unit
`default_nettype none
interface wk_chip_if;
  logic chip_valid;
  logic chip_data;
  logic restart;
  logic [15:0] pattern;
  logic done;
  logic viol;
  logic change;
  logic hit;
  modport det (
    input chip_valid,
    input chip_data,
    input restart,
    input pattern,
    output done,
    output viol,
    output change,
    output hit
  );
  modport drive (
    output chip_valid,
    output chip_data,
    output restart,
    output pattern,
    input done,
    input viol,
    input change,
    input hit
  );
  modport watch (
    input done,
    input viol
  );
endinterface
`default_nettype wire

// ---- src/wk_pkg.sv ----
// constants, register map and types of the wake-up detection unit
`default_nettype none
package wk_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CRIT_A = 8'h25;
  localparam logic [7:0] IDX_PAT_LOW_A = 8'h26;
  localparam logic [7:0] IDX_PAT_HIGH_A = 8'h27;
  localparam logic [7:0] IDX_CHIP_COUNT_A = 8'h28;
  localparam logic [7:0] IDX_CRIT_B = 8'h46;
  localparam logic [7:0] IDX_PAT_LOW_B = 8'h47;
  localparam logic [7:0] IDX_PAT_HIGH_B = 8'h48;
  localparam logic [7:0] IDX_CHIP_COUNT_B = 8'h49;
  localparam logic [7:0] IDX_PROP_A = 8'h73;
  localparam logic [7:0] IDX_INTEG_A = 8'h74;
  localparam logic [7:0] IDX_SYNC_PREAMBLE_A = 8'h75;
  localparam logic [7:0] IDX_VWIN_A = 8'h77;
  localparam logic [7:0] IDX_PROP_B = 8'h93;
  localparam logic [7:0] IDX_INTEG_B = 8'h94;
  localparam logic [7:0] IDX_SYNC_PREAMBLE_B = 8'h95;
  localparam logic [7:0] IDX_VWIN_B = 8'h97;
  localparam logic [7:0] IDX_CONTROL = 8'h10;
  localparam logic [7:0] IDX_STATUS = 8'h11;
  localparam int unsigned PADDR_W = 12;
  // slots of one configuration set
  localparam logic [2:0] SLOT_CRIT = 3'h0;
  localparam logic [2:0] SLOT_PAT_LOW = 3'h1;
  localparam logic [2:0] SLOT_PAT_HIGH = 3'h2;
  localparam logic [2:0] SLOT_CHIP_COUNT = 3'h3;
  localparam logic [2:0] SLOT_PROP = 3'h4;
  localparam logic [2:0] SLOT_INTEG = 3'h5;
  localparam logic [2:0] SLOT_SYNC_PREAMBLE = 3'h6;
  localparam logic [2:0] SLOT_VWIN = 3'h7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // control and status bit positions
  localparam int unsigned CTRL_POLL_BIT = 0;
  localparam int unsigned CTRL_SET_B_BIT = 1;
  localparam int unsigned STAT_SYNC_BIT = 0;
  localparam int unsigned STAT_ACTIVE_BIT = 1;
  localparam int unsigned STAT_WAKE_BIT = 2;
  localparam int unsigned STAT_ABORT_BIT = 3;
  // field msbs, all fields start at bit 0
  localparam int unsigned CRIT_MSB = 1;
  localparam int unsigned SYNC_PREAMBLE_MSB = 1;
  localparam int unsigned CHIP_COUNT_MSB = 6;
  typedef enum logic [1:0] {
    WK_MODE_PATTERN = 2'h0,
    WK_MODE_RANDOM = 2'h1,
    WK_MODE_EQUAL = 2'h2,
    WK_MODE_RATE = 2'h3
  } wk_mode_t;
  typedef enum logic [2:0] {
    WK_ST_IDLE = 3'h1,
    WK_ST_SYNC_PREAMBLE = 3'h2,
    WK_ST_OBSERVE = 3'h4
  } wk_state_t;
  // run-in length codes in chips, code 01 is three and a half bits
  localparam logic [3:0] SYNC_PREAMBLE_CHIPS_0 = 4'h6;
  localparam logic [3:0] SYNC_PREAMBLE_CHIPS_1 = 4'h7;
  localparam logic [3:0] SYNC_PREAMBLE_CHIPS_2 = 4'h8;
  localparam logic [3:0] SYNC_PREAMBLE_CHIPS_3 = 4'h9;
  // sync must come within four symbols of run-in
  localparam logic [3:0] SYNC_PREAMBLE_SEARCH_CHIPS = 4'h8;
  // sync search timeout 7.625 bits, held in eighths of a bit
  localparam int unsigned SYNC_TIMEOUT_EIGHTHS = 61;
  localparam int unsigned SIXTEENTHS_PER_EIGHTH = 2;
  localparam logic [6:0] SYNC_TIMEOUT_TICKS =
    7'(SYNC_TIMEOUT_EIGHTHS * SIXTEENTHS_PER_EIGHTH);
  localparam logic [4:0] PATTERN_CHIPS = 5'h10;
  localparam logic [4:0] CHANGE_DEPTH = 5'h01;
  localparam logic [4:0] VIOL_DEPTH = 5'h02;
endpackage
`default_nettype wire

// ---- src/wk_recovery_lock.sv ----
// lock and unlock supervision of the clock recovery loop
`default_nettype none
module wk_recovery_lock (
  input wire logic pclk,
  input wire logic presetn,
  wk_chip_if.watch chip,
  input wire logic ref_edge,
  input wire logic sixteenth_tick,
  input wire logic frame_gap,
  input wire logic end_of_message,
  input wire logic [1:0] sync_preamble_code,
  input wire logic [7:0] violation_window,
  output logic locked
);
  typedef struct packed {
    logic locked;
    logic [3:0] good;
    logic [8:0] silent;
  } wk_lock_state_t;

  wk_lock_state_t s;
  wk_lock_state_t next_s;
  logic [3:0] sync_preamble_chips;
  logic [8:0] silent_inc;

  always_comb begin
    unique case (sync_preamble_code)
      2'h0: sync_preamble_chips = wk_pkg::SYNC_PREAMBLE_CHIPS_0;
      2'h1: sync_preamble_chips = wk_pkg::SYNC_PREAMBLE_CHIPS_1;
      2'h2: sync_preamble_chips = wk_pkg::SYNC_PREAMBLE_CHIPS_2;
      2'h3: sync_preamble_chips = wk_pkg::SYNC_PREAMBLE_CHIPS_3;
    endcase
  end

  assign silent_inc = s.silent + 9'h001;

  always_comb begin
    next_s = s;
    if (end_of_message) begin
      next_s = '0;
    end else if (!frame_gap) begin
      if (!s.locked) begin
        if (chip.done) begin
          if (chip.viol) begin
            next_s.good = '0;
          end else if (s.good + 4'h1 >= sync_preamble_chips) begin
            next_s.locked = 1'b1;
            next_s.good = '0;
            next_s.silent = '0;
          end else begin
            next_s.good = s.good + 4'h1;
          end
        end
      end else if (ref_edge) begin
        next_s.silent = '0;
      end else if (sixteenth_tick) begin
        // window in sixteenths of a bit
        if (silent_inc > {1'b0, violation_window}) begin
          next_s.locked = 1'b0;
          next_s.silent = '0;
        end else begin
          next_s.silent = silent_inc;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign locked = s.locked;
endmodule
`default_nettype wire

// ---- src/wk_wake_unit.sv ----
// wake-up generation unit with dual configuration and apb registers
//
// Function
// - recovery unlocks after edge-free violation window
// - frame gap freezes loop and window timer
// - window in sixteenths of a bit
// - run-in code 01 means 3.5 bits
// - self polling only, two configuration sets
// - abort unless sync within four symbols
// - abort on sync loss, else count chips
// - chip counter closes the wake window
// - three equal chips are a violation
// - two equal chips mark a bit change
// - search 16-chip pattern from two registers
// - two-bit field selects the criterion
// - pattern stops at window end or sync loss
// - equal bits wakes unless a bit differs
// - random bits wakes unless violation occurs
// - rate mode wakes on sync before timeout
// - lock after four correct coded bits, here after the run-in of 6 to 9 chips (3 to 4.5 bits) set by the run-in code
// - end of message unlocks the recovery
// - chip count 0..127, zero rules per mode
//
// Our own choice: register access over APB.
`default_nettype none
module wk_wake_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_valid,
  input wire logic chip_data,
  input wire logic ref_edge,
  input wire logic sixteenth_tick,
  input wire logic frame_gap,
  input wire logic end_of_message,
  input wire logic poll_start,
  output logic wake_found,
  output logic search_abort,
  output logic search_active,
  output logic symbol_sync,
  output logic [7:0] recovery_proportional_params,
  output logic [7:0] recovery_integral_params
);
  typedef struct packed {
    wk_pkg::wk_state_t state;
    // both configuration sets, eight write-only slots each
    logic [1:0][7:0][7:0] cfg;
    logic poll_en;
    logic set_b;
    logic [6:0] chip_cnt;
    logic [6:0] tick_cnt;
    logic [3:0] sync_preamble_cnt;
    logic restart;
    logic result_wake;
    logic result_abort;
    logic wake_found;
    logic search_abort;
    logic active;
    logic [7:0] prop;
    logic [7:0] integ;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wk_top_state_t;

  wk_top_state_t s;
  wk_top_state_t next_s;
  wk_chip_if chip ();
  logic locked;

  // one address decode for both reads and writes
  logic [7:0] idx;
  logic addr_ok;
  logic map_cfg;
  logic map_set;
  logic [2:0] map_slot;

  always_comb begin
    map_cfg = 1'b1;
    map_set = 1'b0;
    map_slot = wk_pkg::SLOT_CRIT;
    unique case (idx)
      wk_pkg::IDX_CRIT_A: map_slot = wk_pkg::SLOT_CRIT;
      wk_pkg::IDX_PAT_LOW_A: map_slot = wk_pkg::SLOT_PAT_LOW;
      wk_pkg::IDX_PAT_HIGH_A: map_slot = wk_pkg::SLOT_PAT_HIGH;
      wk_pkg::IDX_CHIP_COUNT_A: map_slot = wk_pkg::SLOT_CHIP_COUNT;
      wk_pkg::IDX_PROP_A: map_slot = wk_pkg::SLOT_PROP;
      wk_pkg::IDX_INTEG_A: map_slot = wk_pkg::SLOT_INTEG;
      wk_pkg::IDX_SYNC_PREAMBLE_A: map_slot = wk_pkg::SLOT_SYNC_PREAMBLE;
      wk_pkg::IDX_VWIN_A: map_slot = wk_pkg::SLOT_VWIN;
      wk_pkg::IDX_CRIT_B: begin
        map_set = 1'b1;
        map_slot = wk_pkg::SLOT_CRIT;
      end
      wk_pkg::IDX_PAT_LOW_B: begin
        map_set = 1'b1;
        map_slot = wk_pkg::SLOT_PAT_LOW;
      end
      wk_pkg::IDX_PAT_HIGH_B: begin
        map_set = 1'b1;
        map_slot = wk_pkg::SLOT_PAT_HIGH;
      end
      wk_pkg::IDX_CHIP_COUNT_B: begin
        map_set = 1'b1;
        map_slot = wk_pkg::SLOT_CHIP_COUNT;
      end
      wk_pkg::IDX_PROP_B: begin
        map_set = 1'b1;
        map_slot = wk_pkg::SLOT_PROP;
      end
      wk_pkg::IDX_INTEG_B: begin
        map_set = 1'b1;
        map_slot = wk_pkg::SLOT_INTEG;
      end
      wk_pkg::IDX_SYNC_PREAMBLE_B: begin
        map_set = 1'b1;
        map_slot = wk_pkg::SLOT_SYNC_PREAMBLE;
      end
      wk_pkg::IDX_VWIN_B: begin
        map_set = 1'b1;
        map_slot = wk_pkg::SLOT_VWIN;
      end
      default: map_cfg = 1'b0;
    endcase
  end

  assign idx = paddr[9:2];
  // upper address bits must be zero, else the access is refused
  assign addr_ok = (paddr[11:10] == 2'h0) && (map_cfg || idx == wk_pkg::IDX_CONTROL
    || idx == wk_pkg::IDX_STATUS);

  // active configuration set
  logic [7:0] crit_reg;
  logic [15:0] pattern;
  logic [6:0] chip_count;
  wk_pkg::wk_mode_t mode;

  assign crit_reg = s.cfg[s.set_b][wk_pkg::SLOT_CRIT];
  assign mode = wk_pkg::wk_mode_t'(crit_reg[wk_pkg::CRIT_MSB:0]);
  assign pattern = {s.cfg[s.set_b][wk_pkg::SLOT_PAT_HIGH],
    s.cfg[s.set_b][wk_pkg::SLOT_PAT_LOW]};
  assign chip_count = s.cfg[s.set_b][wk_pkg::SLOT_CHIP_COUNT][wk_pkg::CHIP_COUNT_MSB:0];

  assign chip.chip_valid = chip_valid;
  assign chip.chip_data = chip_data;
  assign chip.restart = s.restart;
  assign chip.pattern = pattern;

  wk_chip_detect wk_chip_detect_i (
    .pclk(pclk),
    .presetn(presetn),
    .chip(chip.det)
  );

  wk_recovery_lock wk_recovery_lock_i (
    .pclk(pclk),
    .presetn(presetn),
    .chip(chip.watch),
    .ref_edge(ref_edge),
    .sixteenth_tick(sixteenth_tick),
    .frame_gap(frame_gap),
    .end_of_message(end_of_message),
    .sync_preamble_code(s.cfg[s.set_b][wk_pkg::SLOT_SYNC_PREAMBLE][wk_pkg::SYNC_PREAMBLE_MSB:0]),
    .violation_window(s.cfg[s.set_b][wk_pkg::SLOT_VWIN]),
    .locked(locked)
  );

  logic [6:0] chip_next;
  logic [31:0] status_word;
  logic [31:0] control_word;

  assign chip_next = s.chip_cnt + 7'h01;

  always_comb begin
    status_word = '0;
    status_word[wk_pkg::STAT_SYNC_BIT] = locked;
    status_word[wk_pkg::STAT_ACTIVE_BIT] = s.active;
    status_word[wk_pkg::STAT_WAKE_BIT] = s.result_wake;
    status_word[wk_pkg::STAT_ABORT_BIT] = s.result_abort;
    control_word = '0;
    control_word[wk_pkg::CTRL_POLL_BIT] = s.poll_en;
    control_word[wk_pkg::CTRL_SET_B_BIT] = s.set_b;
  end

  always_comb begin
    next_s = s;
    next_s.wake_found = 1'b0;
    next_s.search_abort = 1'b0;
    next_s.restart = 1'b0;
    next_s.pready = 1'b0;
    // loop settings follow the active set one cycle later
    next_s.prop = s.cfg[s.set_b][wk_pkg::SLOT_PROP];
    next_s.integ = s.cfg[s.set_b][wk_pkg::SLOT_INTEG];

    // apb: answer prepared in setup, ready in the access cycle
    if (psel && !penable) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !addr_ok;
      next_s.prdata = '0;
      if (idx == wk_pkg::IDX_STATUS && addr_ok) begin
        next_s.prdata = status_word;
      end else if (idx == wk_pkg::IDX_CONTROL && addr_ok) begin
        next_s.prdata = control_word;
      end
    end
    // a write lands only at the access edge, once
    if (psel && penable && s.pready && pwrite && addr_ok) begin
      if (map_cfg) begin
        next_s.cfg[map_set][map_slot] = pwdata[7:0];
      end else if (idx == wk_pkg::IDX_CONTROL) begin
        next_s.poll_en = pwdata[wk_pkg::CTRL_POLL_BIT];
        next_s.set_b = pwdata[wk_pkg::CTRL_SET_B_BIT];
      end
    end

    // wake-up search sequencer
    unique case (s.state)
      wk_pkg::WK_ST_IDLE: begin
        if (poll_start && s.poll_en) begin
          next_s.state = wk_pkg::WK_ST_SYNC_PREAMBLE;
          next_s.sync_preamble_cnt = '0;
          next_s.tick_cnt = '0;
          // clear detector history so old chips cannot trip a flag
          next_s.restart = 1'b1;
          next_s.result_wake = 1'b0;
          next_s.result_abort = 1'b0;
        end
      end

      wk_pkg::WK_ST_SYNC_PREAMBLE: begin
        // wait for lock, rate mode times out on ticks instead of chips
        if (locked) begin
          next_s.chip_cnt = '0;
          next_s.restart = 1'b1;
          // a zero window decides at once, pattern mode cannot match
          if (mode == wk_pkg::WK_MODE_RATE) begin
            next_s.wake_found = 1'b1;
          end else if (chip_count == '0 && mode == wk_pkg::WK_MODE_PATTERN) begin
            next_s.search_abort = 1'b1;
          end else if (chip_count == '0) begin
            next_s.wake_found = 1'b1;
          end else begin
            next_s.state = wk_pkg::WK_ST_OBSERVE;
          end
        end else if (mode == wk_pkg::WK_MODE_RATE) begin
          if (sixteenth_tick) begin
            if (s.tick_cnt + 7'h01 >= wk_pkg::SYNC_TIMEOUT_TICKS) begin
              next_s.search_abort = 1'b1;
            end else begin
              next_s.tick_cnt = s.tick_cnt + 7'h01;
            end
          end
        end else if (chip.done) begin
          if (s.sync_preamble_cnt + 4'h1 >= wk_pkg::SYNC_PREAMBLE_SEARCH_CHIPS) begin
            next_s.search_abort = 1'b1;
          end else begin
            next_s.sync_preamble_cnt = s.sync_preamble_cnt + 4'h1;
          end
        end
      end

      wk_pkg::WK_ST_OBSERVE: begin
        if (!locked) begin
          next_s.search_abort = 1'b1;
        end else if (chip.done) begin
          next_s.chip_cnt = chip_next;
          unique case (mode)
            // a hit wins over window end on the same chip
            wk_pkg::WK_MODE_PATTERN: begin
              if (chip.hit) begin
                next_s.wake_found = 1'b1;
              end else if (chip_next >= chip_count) begin
                next_s.search_abort = 1'b1;
              end
            end
            wk_pkg::WK_MODE_RANDOM: begin
              if (chip.viol) begin
                next_s.search_abort = 1'b1;
              end else if (chip_next >= chip_count) begin
                next_s.wake_found = 1'b1;
              end
            end
            wk_pkg::WK_MODE_EQUAL: begin
              if (chip.change) begin
                next_s.search_abort = 1'b1;
              end else if (chip_next >= chip_count) begin
                next_s.wake_found = 1'b1;
              end
            end
            wk_pkg::WK_MODE_RATE: begin
              // not reached, rate mode decides at sync
              next_s.wake_found = 1'b1;
            end
          endcase
        end
      end
    endcase

    // a result or disabled polling ends the search
    if (next_s.wake_found || next_s.search_abort) begin
      next_s.state = wk_pkg::WK_ST_IDLE;
      next_s.result_wake = next_s.wake_found;
      next_s.result_abort = next_s.search_abort;
    end else if (!s.poll_en && s.state != wk_pkg::WK_ST_IDLE) begin
      next_s.state = wk_pkg::WK_ST_IDLE;
      next_s.search_abort = 1'b1;
      next_s.result_abort = 1'b1;
    end
    next_s.active = next_s.state != wk_pkg::WK_ST_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      // all zero is not a legal one-hot state
      s.state <= wk_pkg::WK_ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // every output below is a flop of the state, symbol_sync one of the lock supervisor state
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign wake_found = s.wake_found;
  assign search_abort = s.search_abort;
  assign search_active = s.active;
  assign symbol_sync = locked;
  assign recovery_proportional_params = s.prop;
  assign recovery_integral_params = s.integ;
endmodule
`default_nettype wire
